// *** rtl/boot_loader_pkg.sv ***
`default_nettype none
package boot_loader_pkg;
    localparam int CODE_RAM_BYTES = 4096;
    localparam int CODE_ADDR_W = 12;
    localparam int BLOCK_BYTES = 256;
    localparam logic [7:0] EEPROM_READ_CMD = 8'h03;
    localparam int EEPROM_ADDR_W = 16;
    localparam int HDR_SPEED_BIT = 3;
    localparam int HDR_XO_LSB = 0;
    localparam int HDR_XO_W = 3;
    localparam logic [7:0] HEADER_BYTES = 8'h03;
    localparam int MCLK_HZ = 125000000;
    localparam int SCK_FAST_HZ = 1000000;
    localparam int SCK_SLOW_HZ = 500000;
    localparam int HALF_FAST = (MCLK_HZ + 2 * SCK_FAST_HZ - 1) / (2 * SCK_FAST_HZ);
    localparam int HALF_SLOW = (MCLK_HZ + 2 * SCK_SLOW_HZ - 1) / (2 * SCK_SLOW_HZ);
    localparam int DIV_W = 8;
    localparam logic [2:0] XO_4MHZ = 3'h0;
    localparam logic [2:0] XO_8MHZ = 3'h1;
    localparam logic [2:0] XO_12MHZ = 3'h2;
    localparam logic [2:0] XO_16MHZ = 3'h3;
    localparam logic [2:0] XO_20MHZ = 3'h4;
    localparam int XO_MHZ_4 = 4;
    localparam int XO_MHZ_20 = 20;
    localparam logic [DIV_W-1:0] BOOT_HALF_RESET = 8'(HALF_SLOW);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_HDR = 3'b011,
        ST_SKIP = 3'b010,
        ST_COPY = 3'b110,
        ST_DONE = 3'b111
    } loader_state_t;
endpackage : boot_loader_pkg
`default_nettype wire

// *** rtl/spi_byte_engine.sv ***
`default_nettype none
// SPI mode 0 byte shifter, MSB first; half period reloaded from the input at every sck edge
module spi_byte_engine
    import boot_loader_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic [DIV_W-1:0] half_period,
    input wire logic miso,
    output logic sck,
    output logic mosi,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte
);
    logic [1:0] miso_sync;
    logic [DIV_W-1:0] cnt, next_cnt;
    logic [3:0] edges, next_edges;
    logic [7:0] sh_tx, next_sh_tx, sh_rx, next_sh_rx, next_rx_byte;
    logic next_sck, next_busy, next_done, next_mosi;

    // Two-stage sync of data from the EEPROM
    always_ff @(posedge mclk) begin
        if (rst) miso_sync <= 2'h0;
        else miso_sync <= {miso_sync[0], miso};
    end

    // Next-state for the shifter
    always_comb begin
        next_cnt = cnt;
        next_edges = edges;
        next_sh_tx = sh_tx;
        next_sh_rx = sh_rx;
        next_rx_byte = rx_byte;
        next_sck = sck;
        next_busy = busy;
        next_done = 1'b0;
        next_mosi = mosi;
        if (!busy) begin
            if (start) begin
                next_busy = 1'b1;
                next_cnt = half_period;
                next_edges = 4'h0;
                next_sh_tx = {tx_byte[6:0], 1'b0};
                next_mosi = tx_byte[7];
            end
        end else if (cnt > 8'h1) begin
            next_cnt = cnt - 8'h1;
        end else begin
            next_cnt = half_period;
            next_sck = ~sck;
            if (!sck) begin
                next_sh_rx = {sh_rx[6:0], miso_sync[1]}; // Sample on rising edge
            end else begin
                next_edges = edges + 4'h1;
                next_mosi = sh_tx[7];                    // Shift on falling edge
                next_sh_tx = {sh_tx[6:0], 1'b0};
                if (edges == 4'h7) begin
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_rx_byte = sh_rx;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt <= 8'h0;
            edges <= 4'h0;
            sh_tx <= 8'h0;
            sh_rx <= 8'h0;
            rx_byte <= 8'h0;
            sck <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            mosi <= 1'b0;
        end else begin
            cnt <= next_cnt;
            edges <= next_edges;
            sh_tx <= next_sh_tx;
            sh_rx <= next_sh_rx;
            rx_byte <= next_rx_byte;
            sck <= next_sck;
            busy <= next_busy;
            done <= next_done;
            mosi <= next_mosi;
        end
    end
endmodule // spi_byte_engine
`default_nettype wire

// *** rtl/spi_eeprom_boot_loader.sv ***
`default_nettype none
module spi_eeprom_boot_loader
    import boot_loader_pkg::*;
#(
    parameter int RAM_BYTES = CODE_RAM_BYTES,
    parameter int XTAL_SCALE_EN = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_cause_register,
    input wire logic eeprom_miso,
    output logic eeprom_sck,
    output logic eeprom_mosi,
    output logic eeprom_cs_n,
    output logic cpu_run,
    output logic loading,
    output logic [2:0] crystal_freq_code,
    output logic eeprom_slow,
    input wire logic cpu_we,
    input wire logic [CODE_ADDR_W-1:0] cpu_data_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic [CODE_ADDR_W-1:0] cpu_code_addr,
    output logic [7:0] cpu_code
);
    logic [7:0] code_ram [RAM_BYTES];
    loader_state_t state, next_state;
    logic [7:0] cmd_idx, next_cmd_idx;
    logic [7:0] hdr_idx, next_hdr_idx;
    logic [7:0] offset_n, next_offset_n;
    logic [7:0] blocks, next_blocks;
    logic [7:0] skip_cnt, next_skip_cnt;
    logic [19:0] copy_cnt, next_copy_cnt;
    logic [19:0] copy_total;
    logic [DIV_W-1:0] half, next_half;
    logic [2:0] next_xo;
    logic next_slow;
    logic spi_start;
    logic [7:0] spi_tx, spi_rx;
    logic spi_busy, spi_done;
    logic ram_we;
    logic [CODE_ADDR_W-1:0] ram_addr;

    // Half SCK period in mclk cycles from the header nibble
    function automatic logic [DIV_W-1:0] half_from_header(input logic [7:0] hb);
        int base;
        int mhz;
        base = hb[HDR_SPEED_BIT] ? HALF_SLOW : HALF_FAST;
        case (hb[HDR_XO_LSB +: HDR_XO_W])
            XO_4MHZ: mhz = XO_MHZ_4;
            XO_8MHZ: mhz = 8;
            XO_12MHZ: mhz = 12;
            XO_16MHZ: mhz = 16;
            default: mhz = XO_MHZ_20;
        endcase
        // Crystal scaling never lengthens it, so the clamp returns the selected rate
        if (XTAL_SCALE_EN != 0) base = (base * mhz + XO_MHZ_20 - 1) / XO_MHZ_20;
        if (base < (hb[HDR_SPEED_BIT] ? HALF_SLOW : HALF_FAST))
            base = hb[HDR_SPEED_BIT] ? HALF_SLOW : HALF_FAST;
        return DIV_W'(base);
    endfunction

    spi_byte_engine u_spi (
        .mclk(mclk),
        .rst(rst),
        .start(spi_start),
        .tx_byte(spi_tx),
        .half_period(half),
        .miso(eeprom_miso),
        .sck(eeprom_sck),
        .mosi(eeprom_mosi),
        .busy(spi_busy),
        .done(spi_done),
        .rx_byte(spi_rx)
    );

    // Byte count to copy is the block count times 256
    // Width leaves room for a full 255-block image
    assign copy_total = {4'h0, blocks, 8'h0};

    // Sequencer: command, header, skip to N, copy blocks
    always_comb begin
        next_state = state;
        next_cmd_idx = cmd_idx;
        next_hdr_idx = hdr_idx;
        next_offset_n = offset_n;
        next_blocks = blocks;
        next_skip_cnt = skip_cnt;
        next_copy_cnt = copy_cnt;
        next_half = half;
        next_xo = crystal_freq_code;
        next_slow = eeprom_slow;
        spi_start = 1'b0;
        spi_tx = 8'h0;
        ram_we = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (!reset_cause_register) next_state = ST_CMD;
                else next_state = ST_DONE;
            end
            ST_CMD: begin
                // READ opcode then 16-bit address 0x0000
                spi_tx = (cmd_idx == 8'h0) ? EEPROM_READ_CMD : 8'h0;
                if (!spi_busy && !spi_done) spi_start = 1'b1;
                if (spi_done) begin
                    next_cmd_idx = cmd_idx + 8'h1;
                    if (cmd_idx == 8'h2) next_state = ST_HDR;
                end
            end
            ST_HDR: begin
                // Rate byte, offset byte, block count byte in that order
                // New rate applies from the second header byte onwards
                if (!spi_busy && !spi_done) spi_start = 1'b1;
                if (spi_done) begin
                    next_hdr_idx = hdr_idx + 8'h1;
                    unique case (hdr_idx)
                        8'h0: begin
                            next_half = half_from_header(spi_rx);
                            next_slow = spi_rx[HDR_SPEED_BIT];
                            next_xo = spi_rx[HDR_XO_LSB +: HDR_XO_W];
                        end
                        8'h1: next_offset_n = spi_rx;
                        default: begin
                            next_blocks = spi_rx;
                            next_skip_cnt = HEADER_BYTES;
                            next_copy_cnt = 20'h0;
                            if (spi_rx == 8'h0) next_state = ST_DONE;
                            else if (offset_n <= HEADER_BYTES) next_state = ST_COPY;
                            else next_state = ST_SKIP;
                        end
                    endcase
                end
            end
            ST_SKIP: begin
                // Discard user data before offset N
                if (!spi_busy && !spi_done) spi_start = 1'b1;
                if (spi_done) begin
                    next_skip_cnt = skip_cnt + 8'h1;
                    if (skip_cnt + 8'h1 == offset_n) next_state = ST_COPY;
                end
            end
            ST_COPY: begin
                // Each received byte lands at the next code address
                // Bytes past the end of code RAM are read but dropped
                if (!spi_busy && !spi_done) spi_start = 1'b1;
                if (spi_done) begin
                    ram_we = (copy_cnt < 20'(RAM_BYTES));
                    next_copy_cnt = copy_cnt + 20'h1;
                    if (copy_cnt + 20'h1 == copy_total) next_state = ST_DONE;
                end
            end
            ST_DONE: next_state = ST_DONE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            cmd_idx <= 8'h0;
            hdr_idx <= 8'h0;
            offset_n <= 8'h0;
            blocks <= 8'h0;
            skip_cnt <= 8'h0;
            copy_cnt <= 20'h0;
            half <= BOOT_HALF_RESET; // Slowest rate until header is read
            crystal_freq_code <= 3'h0;
            eeprom_slow <= 1'b0;
        end else begin
            state <= next_state;
            cmd_idx <= next_cmd_idx;
            hdr_idx <= next_hdr_idx;
            offset_n <= next_offset_n;
            blocks <= next_blocks;
            skip_cnt <= next_skip_cnt;
            copy_cnt <= next_copy_cnt;
            half <= next_half;
            crystal_freq_code <= next_xo;
            eeprom_slow <= next_slow;
        end
    end

    // Loader owns the write port while loading, CPU afterwards
    assign ram_addr = loading ? copy_cnt[CODE_ADDR_W-1:0] : cpu_data_addr;

    // Code RAM: data and code read ports, one write port
    always_ff @(posedge mclk) begin
        if (ram_we) code_ram[ram_addr] <= spi_rx;
        else if (cpu_we && cpu_run) code_ram[cpu_data_addr] <= cpu_wdata;
        cpu_rdata <= code_ram[cpu_data_addr];
        cpu_code <= code_ram[cpu_code_addr];
    end

    // Status and chip select decode straight from the state register
    // Chip select stays low across the whole read so the address auto-increments
    assign loading = (state != ST_DONE) && (state != ST_IDLE);
    assign cpu_run = (state == ST_DONE);
    assign eeprom_cs_n = !(state == ST_CMD || state == ST_HDR ||
                           state == ST_SKIP || state == ST_COPY);
endmodule // spi_eeprom_boot_loader
`default_nettype wire

// *** verif/eeprom_model.sv ***
`default_nettype none
module eeprom_model (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    output logic miso,
    output logic [23:0] cmd,
    output int min_ns
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [512];
    int bits = 0;
    realtime last_rise = 0;
    initial miso = 1'b0;
    // New frame restarts the bit count and the rate measure
    always @(negedge cs_n) begin
        bits = 0;
        min_ns = 1000000;
        last_rise = 0;
    end
    // Command and address shift in; shortest sck period is kept
    always @(posedge sck) if (!cs_n) begin
        if (bits < 24) cmd = {cmd[22:0], mosi};
        if (last_rise > 0 && $realtime - last_rise < min_ns) min_ns = int'($realtime - last_rise);
        last_rise = $realtime;
        bits++;
    end
    // Sequential read data, MSB first, launched on the falling edge
    always @(negedge sck) if (!cs_n && bits >= 24) begin
        miso = mem[cmd[8:0] + 9'((bits - 24) / 8)][7 - (bits - 24) % 8];
    end
    // Released line shows the inverse of its last value
    always @(posedge cs_n) miso = ~miso;
endmodule // eeprom_model
`default_nettype wire

// *** verif/loader_monitor.sv ***
`default_nettype none
module loader_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_cause_register,
    input wire logic eeprom_sck,
    input wire logic eeprom_mosi,
    input wire logic eeprom_cs_n,
    input wire logic cpu_run,
    input wire logic [2:0] crystal_freq_code,
    input wire logic eeprom_slow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [15:0] hi_cnt;
    logic [15:0] next_hi_cnt;
    // Length of the current sck high phase, in mclk cycles
    always_comb next_hi_cnt = eeprom_sck ? hi_cnt + 16'h0001 : 16'h0000;
    always_ff @(posedge mclk) hi_cnt <= next_hi_cnt;
    sequence s_boot;
        $fell(rst) && !reset_cause_register;
    endsequence
    sequence s_skip;
        $fell(rst) && reset_cause_register;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        rst |=> eeprom_cs_n && !cpu_run && !eeprom_sck)
        else $error("outputs not idle after reset");
    a_load_start: assert property (s_boot |-> ##[1:4] !eeprom_cs_n)
        else $error("load did not start");
    a_skip_load: assert property (s_skip |-> eeprom_cs_n throughout ##[1:4] cpu_run)
        else $error("load not skipped");
    a_run_after: assert property (!eeprom_cs_n |-> !cpu_run)
        else $error("run while loading");
    a_run_holds: assert property (cpu_run |=> cpu_run)
        else $error("run dropped");
    a_cfg_holds: assert property (cpu_run |=> $stable(crystal_freq_code) && $stable(eeprom_slow))
        else $error("config changed after load");
    a_sck_rate: assert property ($fell(eeprom_sck) |-> hi_cnt >= (eeprom_slow ? 16'h007D : 16'h003F))
        else $error("sck high phase too short");
    a_mosi_steady: assert property (eeprom_sck && $past(eeprom_sck) |-> $stable(eeprom_mosi))
        else $error("mosi moved while sck high");
    a_frame_end: assert property ($rose(eeprom_cs_n) |-> !eeprom_sck)
        else $error("frame ended with sck high");
endmodule // loader_monitor
bind spi_eeprom_boot_loader loader_monitor i_loader_monitor (.mclk(mclk), .rst(rst),
    .reset_cause_register(reset_cause_register), .eeprom_sck(eeprom_sck),
    .eeprom_mosi(eeprom_mosi), .eeprom_cs_n(eeprom_cs_n), .cpu_run(cpu_run),
    .crystal_freq_code(crystal_freq_code), .eeprom_slow(eeprom_slow));
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] hdr;
        logic cause;
        logic slow;
        logic [2:0] xo;
    } row_t;
    row_t rows [6] = '{'{8'h00, 1'b0, 1'b0, 3'h0}, '{8'h09, 1'b0, 1'b1, 3'h1},
        '{8'hF2, 1'b0, 1'b0, 3'h2}, '{8'h0B, 1'b0, 1'b1, 3'h3},
        '{8'h04, 1'b0, 1'b0, 3'h4}, '{8'h0C, 1'b1, 1'b1, 3'h4}};
    logic [11:0] ks [5] = '{12'h000, 12'h001, 12'h002, 12'h080, 12'h0FF};
    logic mclk;
    logic rst = 1'b1;
    logic cause = 1'b0;
    logic we = 1'b0;
    logic [11:0] daddr = 12'h000;
    logic [11:0] caddr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic miso, sck, mosi, cs_n, run, loading, slow;
    logic [2:0] xo;
    logic [7:0] rdata, code;
    logic [23:0] cmd;
    int min_ns;
    int frames = 0;
    int n_fail = 0;
    int checks_done = 0;
    spi_eeprom_boot_loader i_spi_eeprom_boot_loader (.mclk(mclk), .rst(rst),
        .reset_cause_register(cause), .eeprom_miso(miso), .eeprom_sck(sck),
        .eeprom_mosi(mosi), .eeprom_cs_n(cs_n), .cpu_run(run), .loading(loading),
        .crystal_freq_code(xo), .eeprom_slow(slow), .cpu_we(we), .cpu_data_addr(daddr),
        .cpu_wdata(wdata), .cpu_rdata(rdata), .cpu_code_addr(caddr), .cpu_code(code));
    eeprom_model i_eeprom_model (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .cmd(cmd), .min_ns(min_ns));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Count EEPROM frames
    always @(negedge cs_n) frames++;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Header into the image, reset for 6 cycles, wait for the CPU release
    task automatic boot(input logic [7:0] hdr, input logic [7:0] n, input logic [7:0] blk,
        input logic c);
        int i;
        i_eeprom_model.mem[0] = hdr;
        i_eeprom_model.mem[1] = n;
        i_eeprom_model.mem[2] = blk;
        cause = c;
        frames = 0;
        rst = 1'b1;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 400000 && run !== 1'b1; i++) @(negedge mclk);
    endtask
    task automatic chk_code(input logic [11:0] a, input logic [7:0] exp);
        caddr = a;
        @(negedge mclk);
        check(code, exp);
    endtask
    initial begin
        for (int r = 0; r < 6; r++) begin
            boot(rows[r].hdr, 8'h03, 8'h00, rows[r].cause);
            check(run, 1'b1);
            if (rows[r].cause) check(frames, 0);
            else begin
                check(cmd, 24'h030000);
                check(slow, rows[r].slow);
                check(xo, rows[r].xo);
                check({slow, xo}, rows[r].hdr[3:0]);
                check(min_ns >= (rows[r].slow ? 2000 : 1000), 1);
            end
            $display("header row %0d done", r);
        end
        // One block, program starts at offset 5 after two user bytes
        for (int i = 3; i < 300; i++) i_eeprom_model.mem[i] = 8'(i * 7 + 1);
        boot(8'h04, 8'h05, 8'h01, 1'b0);
        check(loading, 1'b0);
        foreach (ks[j]) chk_code(ks[j], 8'(ks[j] * 7 + 36));
        caddr = 12'h100;
        @(negedge mclk);
        check(code !== 8'h24, 1);
        daddr = 12'hFFF;
        wdata = 8'hA5;
        we = 1'b1;
        @(negedge mclk);
        we = 1'b0;
        @(negedge mclk);
        check(rdata, 8'hA5);
        chk_code(12'hFFF, 8'hA5);
        $display("block copy test done");
        report_and_stop();
    end
    // Watchdog well beyond the expected load times
    initial begin
        #5000000;
        n_fail++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
